// *** gxp_defines.svh ***
// Timing counts, register codes and reset values of the expander serial interface
`ifndef GXP_DEFINES_SVH
`define GXP_DEFINES_SVH

`define GXP_CLK_MHZ          100
`define GXP_SPIKE_NS         50
`define GXP_SPIKE_CYC        ((`GXP_SPIKE_NS * `GXP_CLK_MHZ + 999) / 1000)
`define GXP_TIMEOUT_MS       25
`define GXP_TIMEOUT_CYC      (`GXP_TIMEOUT_MS * `GXP_CLK_MHZ * 1000)
`define GXP_CMD_IN0          8'h00
`define GXP_CMD_IN1          8'h01
`define GXP_CMD_OUT0         8'h02
`define GXP_CMD_OUT1         8'h03
`define GXP_CMD_POL0         8'h04
`define GXP_CMD_POL1         8'h05
`define GXP_CMD_CFG0         8'h06
`define GXP_CMD_CFG1         8'h07
`define GXP_CMD_TMO          8'h08
`define GXP_OUT_RST          8'hFF
`define GXP_POL_RST          8'h00
`define GXP_CFG_RST          8'hFF
`define GXP_TMO_RST          8'h01
`define GXP_ADDR_BASE        7'h20

`endif

// *** gxp_pkg.sv ***
// Types shared by the expander serial interface
package gxp_pkg;

    typedef enum logic [2:0] {
        GXP_IDLE = 3'b000,
        GXP_ADDR = 3'b001,
        GXP_AACK = 3'b010,
        GXP_WBYT = 3'b011,
        GXP_WACK = 3'b100,
        GXP_RBYT = 3'b101,
        GXP_RACK = 3'b110
    } gxp_state_t;

    typedef struct packed {
        logic [7:0] lo;
        logic [7:0] hi;
    } gxp_pair_t;

    typedef struct packed {
        logic sda_o;
        logic sda_oe_n;
        logic int_oe_n;
    } gxp_pins_t;

endpackage

// *** gxp_filter.sv ***
// Synchroniser and spike filter for one serial bus input
`timescale 1ns/1ps
module gxp_filter
    import gxp_pkg::*;
#(
    parameter int CYC = 5
) (
    input  wire logic ref_clk,
    input  wire logic resetn,
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic       s1;
        logic       s2;
        logic [7:0] cnt;
        logic       q;
    } gxp_flt_t;

    gxp_flt_t st_r;
    gxp_flt_t st_nxt;

    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = din;
        st_nxt.s2 = st_r.s1;
        if (st_r.s2 == st_r.q) begin
            st_nxt.cnt = 8'h00;
        end else if (st_r.cnt >= 8'(CYC - 1)) begin
            st_nxt.q   = st_r.s2;
            st_nxt.cnt = 8'h00;
        end else begin
            st_nxt.cnt = st_r.cnt + 8'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r <= '{s1: 1'b1, s2: 1'b1, cnt: 8'h00, q: 1'b1};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.q;
endmodule

// *** gxp_i2c_expander.sv ***
// Two-wire slave interface and register set of a 16-bit port expander
//
// Overview of operation
// - Either line low for the lock-up interval resets the serial interface.
// - Timeout register bit 0 clear disables the lock-up timeout.
// - SDA and SCL pass a filter dropping pulses under 50 ns.
// - Sixteen I/O lines, direction and level set over the serial bus.
// - After reset every I/O line is an input.
// - Three select pins choose the 7-bit address among eight values.
// - Device is slave only; it never drives SCL.
// - START, address with R/W, command byte, data bytes, STOP.
// - Idle bus has both lines released high.
// - SDA falling while SCL high is START.
// - SDA rising while SCL high is STOP.
// - After STOP the interface is idle and waits for START.
// - Interrupt output is open-drain active low.
// - R/W bit low writes, high reads.
// - First written byte is the command selecting the register.
// - Successive bytes alternate between the two registers of a pair; the timeout register keeps its command.
`timescale 1ns/1ps
`include "gxp_defines.svh"
module gxp_i2c_expander
    import gxp_pkg::*;
#(
    parameter int TIMEOUT_CYC = `GXP_TIMEOUT_CYC,
    parameter int SPIKE_CYC   = `GXP_SPIKE_CYC
) (
    input  wire logic            ref_clk,
    input  wire logic            resetn,
    input  wire logic            scl_i,
    input  wire logic            sda_i,
    output gxp_pkg::gxp_pins_t   pins,
    input  wire logic            addr_sel_pin0,
    input  wire logic            addr_sel_pin1,
    input  wire logic            addr_sel_pin2,
    input  wire logic [7:0]      port_low_lines_i,
    input  wire logic [7:0]      port_high_lines_i,
    output gxp_pkg::gxp_pair_t   port_o,
    output gxp_pkg::gxp_pair_t   port_oe_n,
    input  wire logic            int_req
);
    import gxp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        gxp_state_t  fsm;
        logic        scl_d;
        logic        sda_d;
        logic [2:0]  a_s1;
        logic [2:0]  a_s2;
        logic [15:0] pin_s1;
        logic [15:0] pin_s2;
        logic        int_s1;
        logic        int_s2;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic        rd;
        logic        have_cmd;
        logic [7:0]  cmd;
        logic        ack_ok;
        logic        nack;
        gxp_pair_t   outp;
        gxp_pair_t   pol;
        gxp_pair_t   cfg;
        logic [7:0]  tmo;
        logic [31:0] low_cnt;
        gxp_pins_t   pins;
        gxp_pair_t   po;
        gxp_pair_t   poe;
    } gxp_st_t;

    gxp_st_t st_r;
    gxp_st_t st_nxt;
    logic    scl_f;
    logic    sda_f;

    ////////////////////////////////////////////////////////////////////////////
    // Filtered bus inputs
    gxp_filter #(.CYC(SPIKE_CYC)) u_flt_scl (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .din     (scl_i),
        .dout    (scl_f)
    );
    gxp_filter #(.CYC(SPIKE_CYC)) u_flt_sda (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .din     (sda_i),
        .dout    (sda_f)
    );

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] rd_reg(input logic [7:0] c, input gxp_st_t s);
        logic [15:0] inv;
        inv = s.pin_s2 ^ {s.pol.hi, s.pol.lo};
        case (c)
            `GXP_CMD_IN0:  rd_reg = inv[7:0];
            `GXP_CMD_IN1:  rd_reg = inv[15:8];
            `GXP_CMD_OUT0: rd_reg = s.outp.lo;
            `GXP_CMD_OUT1: rd_reg = s.outp.hi;
            `GXP_CMD_POL0: rd_reg = s.pol.lo;
            `GXP_CMD_POL1: rd_reg = s.pol.hi;
            `GXP_CMD_CFG0: rd_reg = s.cfg.lo;
            `GXP_CMD_CFG1: rd_reg = s.cfg.hi;
            `GXP_CMD_TMO:  rd_reg = s.tmo;
            default:       rd_reg = 8'hFF;
        endcase
    endfunction

    // Pair partner: flip bit 0 inside the paired range, timeout stays put
    function automatic logic [7:0] next_cmd(input logic [7:0] c);
        if (c < `GXP_CMD_TMO) begin
            next_cmd = c ^ 8'h01;
        end else begin
            next_cmd = c;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic [6:0] my_addr;
    logic [7:0] rbyte;
    logic [7:0] rd_val;

    always_comb begin
        scl_rise = scl_f && !st_r.scl_d;
        scl_fall = !scl_f && st_r.scl_d;
        start_c  = scl_f && st_r.scl_d && st_r.sda_d && !sda_f;
        stop_c   = scl_f && st_r.scl_d && !st_r.sda_d && sda_f;
        my_addr  = `GXP_ADDR_BASE + {1'b0, st_r.a_s2, 3'b000};
        rbyte    = {st_r.sh[6:0], sda_f};
        rd_val   = rd_reg(st_r.cmd, st_r);

        st_nxt        = st_r;
        st_nxt.scl_d  = scl_f;
        st_nxt.sda_d  = sda_f;
        st_nxt.a_s1   = {addr_sel_pin2, addr_sel_pin1, addr_sel_pin0};
        st_nxt.a_s2   = st_r.a_s1;
        st_nxt.pin_s1 = {port_high_lines_i, port_low_lines_i};
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.int_s1 = int_req;
        st_nxt.int_s2 = st_r.int_s1;
        st_nxt.pins.int_oe_n = !st_r.int_s2;
        st_nxt.pins.sda_o    = 1'b0;
        st_nxt.po  = st_r.outp;
        st_nxt.poe = st_r.cfg;

        if (!scl_f || !sda_f) begin
            st_nxt.low_cnt = st_r.low_cnt + 32'h1;
        end else begin
            st_nxt.low_cnt = 32'h0;
        end

        if (scl_rise) begin
            st_nxt.sh = rbyte;
        end

        case (st_r.fsm)
            GXP_IDLE: begin
                st_nxt.pins.sda_oe_n = 1'b1;
            end
            GXP_ADDR: begin
                if (scl_rise) begin
                    st_nxt.bitn = st_r.bitn + 4'h1;
                end
                if (scl_fall && st_r.bitn == 4'h8) begin
                    st_nxt.bitn = 4'h0;
                    st_nxt.rd   = st_r.sh[0];
                    if (st_r.sh[7:1] == my_addr) begin
                        st_nxt.fsm           = GXP_AACK;
                        st_nxt.pins.sda_oe_n = 1'b0;
                    end else begin
                        st_nxt.fsm = GXP_IDLE;
                    end
                end
            end
            GXP_AACK: begin
                if (scl_fall) begin
                    st_nxt.pins.sda_oe_n = 1'b1;
                    if (st_r.rd) begin
                        st_nxt.fsm           = GXP_RBYT;
                        st_nxt.sh            = rd_val;
                        st_nxt.pins.sda_oe_n = rd_val[7];
                    end else begin
                        st_nxt.fsm      = GXP_WBYT;
                        st_nxt.have_cmd = 1'b0;
                    end
                end
            end
            GXP_WBYT: begin
                if (scl_rise) begin
                    st_nxt.bitn = st_r.bitn + 4'h1;
                end
                if (scl_fall && st_r.bitn == 4'h8) begin
                    st_nxt.bitn          = 4'h0;
                    st_nxt.fsm           = GXP_WACK;
                    st_nxt.pins.sda_oe_n = 1'b0;
                    if (!st_r.have_cmd) begin
                        st_nxt.cmd      = st_r.sh;
                        st_nxt.have_cmd = 1'b1;
                    end else begin
                        case (st_r.cmd)
                            `GXP_CMD_OUT0: st_nxt.outp.lo = st_r.sh;
                            `GXP_CMD_OUT1: st_nxt.outp.hi = st_r.sh;
                            `GXP_CMD_POL0: st_nxt.pol.lo  = st_r.sh;
                            `GXP_CMD_POL1: st_nxt.pol.hi  = st_r.sh;
                            `GXP_CMD_CFG0: st_nxt.cfg.lo  = st_r.sh;
                            `GXP_CMD_CFG1: st_nxt.cfg.hi  = st_r.sh;
                            `GXP_CMD_TMO:  st_nxt.tmo     = st_r.sh;
                            default:       st_nxt.tmo     = st_r.tmo;
                        endcase
                        st_nxt.cmd = next_cmd(st_r.cmd);
                    end
                end
            end
            GXP_WACK: begin
                if (scl_fall) begin
                    st_nxt.pins.sda_oe_n = 1'b1;
                    st_nxt.fsm           = GXP_WBYT;
                end
            end
            GXP_RBYT: begin
                // Shift out on falling edges, MSB first
                if (scl_fall) begin
                    st_nxt.bitn = st_r.bitn + 4'h1;
                    if (st_r.bitn == 4'h7) begin
                        st_nxt.bitn          = 4'h0;
                        st_nxt.fsm           = GXP_RACK;
                        st_nxt.pins.sda_oe_n = 1'b1;
                        st_nxt.cmd           = next_cmd(st_r.cmd);
                    end else begin
                        st_nxt.sh            = {st_r.sh[6:0], 1'b1};
                        st_nxt.pins.sda_oe_n = st_r.sh[6];
                    end
                end else if (scl_rise) begin
                    st_nxt.sh = st_r.sh;
                end
            end
            GXP_RACK: begin
                if (scl_rise) begin
                    st_nxt.nack = sda_f;
                end
                if (scl_fall) begin
                    if (st_r.nack) begin
                        st_nxt.fsm = GXP_IDLE;
                    end else begin
                        st_nxt.fsm           = GXP_RBYT;
                        st_nxt.sh            = rd_val;
                        st_nxt.pins.sda_oe_n = rd_val[7];
                    end
                end
            end
            default: begin
                st_nxt.fsm = GXP_IDLE;
            end
        endcase

        // Conditions on the bus override the byte engine
        if (start_c) begin
            st_nxt.fsm           = GXP_ADDR;
            st_nxt.bitn          = 4'h0;
            st_nxt.pins.sda_oe_n = 1'b1;
        end else if (stop_c) begin
            st_nxt.fsm           = GXP_IDLE;
            st_nxt.pins.sda_oe_n = 1'b1;
        end

        if (st_r.tmo[0] && st_r.low_cnt >= 32'(TIMEOUT_CYC)) begin
            st_nxt.fsm           = GXP_IDLE;
            st_nxt.bitn          = 4'h0;
            st_nxt.pins.sda_oe_n = 1'b1;
            st_nxt.low_cnt       = 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st_r          <= '0;
            st_r.fsm      <= GXP_IDLE;
            st_r.scl_d    <= 1'b1;
            st_r.sda_d    <= 1'b1;
            st_r.outp     <= {`GXP_OUT_RST, `GXP_OUT_RST};
            st_r.pol      <= {`GXP_POL_RST, `GXP_POL_RST};
            st_r.cfg      <= {`GXP_CFG_RST, `GXP_CFG_RST};
            st_r.tmo      <= `GXP_TMO_RST;
            st_r.pins     <= '{sda_o: 1'b0, sda_oe_n: 1'b1, int_oe_n: 1'b1};
            st_r.po       <= {`GXP_OUT_RST, `GXP_OUT_RST};
            st_r.poe      <= {`GXP_CFG_RST, `GXP_CFG_RST};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pins      = st_r.pins;
    assign port_o    = st_r.po;
    assign port_oe_n = st_r.poe;
endmodule

// *** gxp_i2c_expander_sva.sv ***
// Port-level assertions of the expander serial interface
`timescale 1ns/1ps
module gxp_i2c_expander_sva
    import gxp_pkg::*;
#(
    parameter int TIMEOUT_CYC = 2000
) (
    input wire logic          ref_clk,
    input wire logic          resetn,
    input wire logic          scl_i,
    input wire logic          sda_i,
    input gxp_pkg::gxp_pins_t pins,
    input gxp_pkg::gxp_pair_t port_o,
    input gxp_pkg::gxp_pair_t port_oe_n,
    input wire logic          int_req
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    // Cycles the device has held SDA low while SCL is low
    int pull_cnt_r;
    int pull_cnt_nxt;
    always_comb begin
        pull_cnt_nxt = (!scl_i && !pins.sda_oe_n) ? pull_cnt_r + 1 : 0;
    end
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn)
            pull_cnt_r <= 0;
        else
            pull_cnt_r <= pull_cnt_nxt;
    end
    chk_sda_open_drain: assert property (pins.sda_o == 1'b0)
        else $error("SDA drive level not low");
    chk_reset_inputs: assert property ($rose(resetn) |-> port_oe_n == 16'hFFFF)
        else $error("lines not inputs after reset");
    chk_int_assert: assert property (int_req [*4] |-> !pins.int_oe_n)
        else $error("interrupt not pulled low");
    chk_int_release: assert property (!int_req [*4] |-> pins.int_oe_n)
        else $error("interrupt not released");
    chk_sda_scl_low: assert property ($changed(pins.sda_oe_n) |-> !scl_i)
        else $error("SDA drive changed while SCL high");
    chk_port_scl_low: assert property ($changed(port_o) || $changed(port_oe_n) |-> !scl_i)
        else $error("port register changed while SCL high");
    chk_stop_idle: assert property (scl_i && $rose(sda_i) |=> pins.sda_oe_n [*8])
        else $error("SDA pulled after stop");
    chk_lockup_bound: assert property (pull_cnt_r <= TIMEOUT_CYC + 40)
        else $error("SDA held past lock-up interval");
endmodule

// *** gxp_bus_master.sv ***
// Two-wire bus master model; released lines read high through pull-ups
`timescale 1ns/1ps
module gxp_bus_master (
    input  wire logic  ref_clk,
    input  wire logic  sda_in,
    output logic       scl,
    output logic       sda,
    output logic [8:0] got
);
    localparam int LO = 10;
    localparam int HI = 6;
    logic spike = 1'b0;
    event done;
    initial begin
        scl = 1'b1;
        sda = 1'b1;
        got = 9'h000;
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // One bit; a short low spike inside the high phase when asked
    task automatic bit_io(input logic b, output logic r);
        cyc(4);
        sda = b;
        cyc(LO - 4);
        scl = 1'b1;
        if (spike) begin
            cyc(6);
            scl = 1'b0;
            cyc(3);
            scl = 1'b1;
            cyc(6);
        end else begin
            cyc(HI - 1);
        end
        r = sda_in;
        cyc(1);
        scl = 1'b0;
    endtask
    // s high gives START or repeated START, s low gives STOP
    task automatic cond(input logic s);
        // Hold SDA briefly past the SCL fall before moving it
        cyc(2);
        sda = s;
        cyc(LO - 2);
        scl = 1'b1;
        cyc(HI);
        sda = !s;
        cyc(HI);
        scl = !s;
    endtask
    // Eight data bits then the acknowledge bit; got is {ack, byte} as the wire showed
    task automatic xfer(input logic [7:0] b, input logic a);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r);
            got[i] = r;
        end
        bit_io(a, r);
        got[8] = r;
        -> done;
    endtask
endmodule

// *** tb.sv ***
// Self-checking testbench of the expander serial interface
`timescale 1ns/1ps
module tb;
    import gxp_pkg::*;
    localparam int TMO = 2000;
    logic        ref_clk;
    logic        resetn;
    logic        int_req;
    logic [2:0]  sel;
    logic [15:0] lines;
    logic        m_scl;
    logic        m_sda;
    logic        sda_w;
    gxp_pins_t   pins;
    gxp_pair_t   port_o;
    gxp_pair_t   port_oe_n;
    logic [15:0] exp_q[$];
    logic [7:0]  regs[9];
    logic [7:0]  v;
    logic [6:0]  dev;
    int          seed;
    int          fail_count;
    int          comparisons;
    gxp_bus_master m (.ref_clk(ref_clk), .sda_in(sda_w), .scl(m_scl), .sda(m_sda), .got());
    assign sda_w = m_sda & (pins.sda_oe_n | pins.sda_o);
    gxp_i2c_expander #(.TIMEOUT_CYC(TMO), .SPIKE_CYC(5)) gxp_i2c_expander_inst (
        .ref_clk(ref_clk), .resetn(resetn), .scl_i(m_scl), .sda_i(sda_w), .pins(pins),
        .addr_sel_pin0(sel[0]), .addr_sel_pin1(sel[1]), .addr_sel_pin2(sel[2]),
        .port_low_lines_i(lines[7:0]), .port_high_lines_i(lines[15:8]),
        .port_o(port_o), .port_oe_n(port_oe_n), .int_req(int_req));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic results();
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic put(input logic [7:0] b, input logic a, input logic [8:0] e);
        exp_q.push_back({7'h00, e});
        m.xfer(b, a);
    endtask
    task automatic head(input logic [7:0] cmd);
        m.cond(1'b1);
        put({dev, 1'b0}, 1'b1, {1'b0, dev, 1'b0});
        put(cmd, 1'b1, {1'b0, cmd});
    endtask
    task automatic wr(input logic [7:0] cmd, input logic [7:0] d[$]);
        head(cmd);
        foreach (d[i]) put(d[i], 1'b1, {1'b0, d[i]});
        m.cond(1'b0);
    endtask
    task automatic rd(input logic [7:0] cmd, input logic [7:0] e[$]);
        head(cmd);
        m.cond(1'b1);
        put({dev, 1'b1}, 1'b1, {1'b0, dev, 1'b1});
        foreach (e[i]) put(8'hFF, i == e.size() - 1, {(i == e.size() - 1), e[i]});
        m.cond(1'b0);
    endtask
    initial forever begin
        @(m.done);
        check({7'h00, m.got}, exp_q.pop_front());
    end
    initial begin
        repeat (100000) @(posedge ref_clk);
        fail_count++;
        results();
    end
    initial begin
        seed = 32'hE7C80BA3;
        resetn = 1'b0;
        int_req = 1'b0;
        sel = 3'h0;
        lines = 16'($random(seed));
        m.cyc(5);
        resetn = 1'b1;
        m.cyc(10);
        check(port_o, 16'hFFFF);
        check(port_oe_n, 16'hFFFF);
        int_req = 1'b1;
        m.cyc(5);
        check({15'h0000, pins.int_oe_n}, 16'h0000);
        int_req = 1'b0;
        m.cyc(5);
        check({15'h0000, pins.int_oe_n}, 16'h0001);
        for (int s = 0; s < 8; s++) begin
            sel = s[2:0];
            dev = 7'h20 + {1'b0, sel, 3'h0};
            v = 8'($random(seed));
            m.cyc(5);
            wr(8'h02, '{v});
            check({8'h00, port_o.lo}, {8'h00, v});
            m.cond(1'b1);
            put({dev ^ 7'h01, 1'b0}, 1'b1, {1'b1, dev ^ 7'h01, 1'b0});
            m.cond(1'b0);
        end
        for (int c = 0; c < 9; c++) begin
            lines = 16'($random(seed));
            int_req = 1'($random(seed));
            regs[c] = (c == 8) ? 8'h01 : 8'($random(seed));
            wr(c[7:0], '{regs[c]});
            v = (c == 0) ? lines[7:0] : (c == 1) ? lines[15:8] : regs[c];
            rd(c[7:0], '{v});
            check({15'h0000, pins.int_oe_n}, {15'h0000, !int_req});
        end
        check(port_o, {regs[2], regs[3]});
        check(port_oe_n, {regs[6], regs[7]});
        lines = 16'($random(seed));
        v = lines[7:0] ^ regs[4];
        rd(8'h00, '{v, lines[15:8] ^ regs[5], v});
        rd(8'h09, '{8'hFF});
        m.spike = 1'b1;
        wr(8'h07, '{8'hA5, 8'h3C, 8'h96});
        check(port_oe_n, 16'h3C96);
        rd(8'h06, '{8'h3C, 8'h96, 8'h3C});
        m.spike = 1'b0;
        wr(8'h04, '{8'h00, 8'h00});
        head(8'h04);
        m.cond(1'b1);
        put({dev, 1'b1}, 1'b1, {1'b0, dev, 1'b1});
        m.cyc(40);
        check({15'h0000, pins.sda_oe_n}, 16'h0000);
        m.cyc(TMO + 60);
        check({15'h0000, pins.sda_oe_n}, 16'h0001);
        m.cond(1'b0);
        check(port_oe_n, 16'h3C96);
        rd(8'h05, '{8'h00});
        wr(8'h08, '{8'h00});
        m.cond(1'b1);
        put({dev, 1'b0}, 1'b1, {1'b0, dev, 1'b0});
        m.cyc(TMO + 60);
        put(8'h02, 1'b1, 9'h002);
        put(8'h5A, 1'b1, 9'h05A);
        m.cond(1'b0);
        check({8'h00, port_o.lo}, 16'h005A);
        wr(8'h08, '{8'h01});
        m.cyc(50);
        results();
    end
endmodule
bind gxp_i2c_expander gxp_i2c_expander_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) gxp_i2c_expander_sva_inst (
    .ref_clk(ref_clk), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .pins(pins),
    .port_o(port_o), .port_oe_n(port_oe_n), .int_req(int_req));
